// ==== design/timer_ctl_defs.vh ====
`ifndef TIMER_CTL_DEFS_VH
`define TIMER_CTL_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFF_TIMER_CONTROL 8'h20
`define OFF_TIMER_GLOBAL_CONTROL 8'h24
`define OFF_UPPER_HALF_COUNTER 8'h18
`define OFF_UPPER_HALF_PERIOD 8'h1c

// ----------------------------------------
// timer_control fields
// ----------------------------------------
`define BIT_OUTPUT_LEVEL_STATUS 0
`define BIT_OUTPUT_INVERT 1
`define BIT_INPUT_INVERT 2
`define BIT_LOWER_CLOCK_SOURCE 8
`define UPPER_ENABLE_MODE_HI 23
`define UPPER_ENABLE_MODE_LO 22

// ----------------------------------------
// timer_global_control fields
// ----------------------------------------
`define BIT_LOWER_RELEASE 0
`define BIT_UPPER_RELEASE 1
`define MODE_HI 3
`define MODE_LO 2
`define PSC_HI 11
`define PSC_LO 8
`define TDD_HI 15
`define TDD_LO 12

// ----------------------------------------
// Encodings and reset values
// ----------------------------------------
`define MODE_GP64 2'h0
`define MODE_DUAL_UNCHAINED 2'h1
`define MODE_WATCHDOG 2'h2
`define MODE_DUAL_CHAINED 2'h3
`define ENA_OFF 2'h0
`define ENA_ONCE 2'h1
`define ENA_CONT 2'h2
`define RESET_WORD 32'h0000_0000
`define INPUT_DIVIDE_RATIO 6
// Pin rising edges per half period of the divided clock, less one
`define DIV_HALF_LAST 3'h2

`endif

// ==== design/timer_mode_prescale_output_ctl.v ====
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ns
`include "timer_ctl_defs.vh"

// ----------------------------------------
// Behaviour notes
// ----------------------------------------
// The upper half counts on the internal clock only; the pin feeds the lower tick.
// The divide-by-six option is built here from the synchronised pin, so the
// divided clock steps only on pin edges that survive the two-flop sync.
// In continuous mode the upper half clears on the next clock after its period whatever the prescale,
// so the period value itself shows for one clock only; once mode holds it there.
// A prescale match that lands on that clearing clock is lost, not carried.
// Reserved enable mode 3h leaves the upper half stopped.
// A counter write wins over counting and over the period clear.
// The output pin lags the raw timer output by two clocks, status by one.
// Mode flags toward the counter slice lag the mode field by one clock.

module timer_mode_prescale_output_ctl #(
  parameter CNT_W = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata_ff,
  // System option and timer signals from the counter slice
  input wire input_divide_select,
  input wire timer_out_raw,
  // Pins
  input wire timer_in_pin,
  output reg timer_out_pin_ff,
  // Decoded state toward the counter slice
  output reg lower_tick_ff,
  output reg [1:0] timer_mode_select_ff,
  output reg mode_is_watchdog_ff,
  output reg mode_is_chained_ff
);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  reg input_invert_ff;
  reg output_invert_ff;
  reg lower_clock_source_ff;
  reg [1:0] upper_enable_mode_ff;
  reg [3:0] upper_prescale_value_ff;
  reg [3:0] upper_divide_down_count_ff;
  reg upper_half_reset_release_ff;
  reg lower_half_reset_release_ff;
  reg [CNT_W-1:0] upper_half_counter_ff;
  reg [CNT_W-1:0] upper_half_period_ff;
  reg output_level_status_ff;
  reg bump_ff;

  // Pin and option synchronisers; stage one is read only by stage two
  reg pin_s1_ff;
  reg pin_s2_ff;
  reg pin_prev_ff;
  reg div_s1_ff;
  reg div_s2_ff;
  reg [2:0] div_cnt_ff;
  reg div_clk_ff;
  reg div_clk_prev_ff;

  // ----------------------------------------
  // Combinational decode
  // ----------------------------------------
  function sel;
    input [7:0] a;
    input [7:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // Mode field compare, shared by the run gate and the mode flags
  function is_mode;
    input [1:0] m;
    input [1:0] code;
    begin
      is_mode = (m == code);
    end
  endfunction

  wire wr_ctl = wr & sel(addr, `OFF_TIMER_CONTROL);
  wire wr_gctl = wr & sel(addr, `OFF_TIMER_GLOBAL_CONTROL);
  wire wr_cnt = wr & sel(addr, `OFF_UPPER_HALF_COUNTER);
  wire wr_prd = wr & sel(addr, `OFF_UPPER_HALF_PERIOD);

  // Raw external level: the divided clock when the divide option is on
  wire ext_level = div_s2_ff ? div_clk_ff : pin_s2_ff;
  wire ext_prev = div_s2_ff ? div_clk_prev_ff : pin_prev_ff;
  // Inversion turns a falling edge into the counted edge
  wire ext_cur_inv = input_invert_ff ? ~ext_level : ext_level;
  wire ext_prev_inv = input_invert_ff ? ~ext_prev : ext_prev;
  wire ext_tick = ext_cur_inv & ~ext_prev_inv;
  // Internal clock ignores the inversion bit entirely
  wire nxt_lower_tick = lower_clock_source_ff ? ext_tick : 1'b1;

  // Upper half enabled only in unchained mode and out of reset
  wire upper_run = is_mode(timer_mode_select_ff, `MODE_DUAL_UNCHAINED)
    & upper_half_reset_release_ff
    & ((upper_enable_mode_ff == `ENA_ONCE) | (upper_enable_mode_ff == `ENA_CONT));
  wire at_period = (upper_half_counter_ff == upper_half_period_ff);
  wire once_done = (upper_enable_mode_ff == `ENA_ONCE) & at_period;
  wire psc_match = (upper_divide_down_count_ff == upper_prescale_value_ff);
  // Upper half shares the internal clock tick here
  wire upper_tick = upper_run & ~once_done;

  reg [31:0] nxt_rdata;

  // Read mux; unmapped addresses and reserved bits read zero
  always @*
  begin
    nxt_rdata = `RESET_WORD;
    if (sel(addr, `OFF_TIMER_CONTROL))
    begin
      nxt_rdata[`UPPER_ENABLE_MODE_HI:`UPPER_ENABLE_MODE_LO] = upper_enable_mode_ff;
      nxt_rdata[`BIT_LOWER_CLOCK_SOURCE] = lower_clock_source_ff;
      nxt_rdata[`BIT_INPUT_INVERT] = input_invert_ff;
      nxt_rdata[`BIT_OUTPUT_INVERT] = output_invert_ff;
      nxt_rdata[`BIT_OUTPUT_LEVEL_STATUS] = output_level_status_ff;
    end
    else if (sel(addr, `OFF_TIMER_GLOBAL_CONTROL))
    begin
      nxt_rdata[`TDD_HI:`TDD_LO] = upper_divide_down_count_ff;
      nxt_rdata[`PSC_HI:`PSC_LO] = upper_prescale_value_ff;
      nxt_rdata[`MODE_HI:`MODE_LO] = timer_mode_select_ff;
      nxt_rdata[`BIT_UPPER_RELEASE] = upper_half_reset_release_ff;
      nxt_rdata[`BIT_LOWER_RELEASE] = lower_half_reset_release_ff;
    end
    else if (sel(addr, `OFF_UPPER_HALF_COUNTER))
    begin
      nxt_rdata[CNT_W-1:0] = upper_half_counter_ff;
    end
    else if (sel(addr, `OFF_UPPER_HALF_PERIOD))
    begin
      nxt_rdata[CNT_W-1:0] = upper_half_period_ff;
    end
  end

  // ----------------------------------------
  // Register writes and bus read
  // ----------------------------------------
  // Read data stands one cycle after the strobe and is zero otherwise
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_ff <= `RESET_WORD;
    end
    else
    begin
      rdata_ff <= rd ? nxt_rdata : `RESET_WORD;
    end
  end

  // Software-only fields; status bit 0 of control ignores writes
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      input_invert_ff <= 1'b0;
      output_invert_ff <= 1'b0;
      lower_clock_source_ff <= 1'b0;
      upper_enable_mode_ff <= `ENA_OFF;
      upper_prescale_value_ff <= 4'h0;
      timer_mode_select_ff <= `MODE_GP64;
      upper_half_reset_release_ff <= 1'b0;
      lower_half_reset_release_ff <= 1'b0;
      upper_half_period_ff <= {CNT_W{1'b0}};
    end
    else
    begin
      if (wr_ctl)
      begin
        upper_enable_mode_ff <= wdata[`UPPER_ENABLE_MODE_HI:`UPPER_ENABLE_MODE_LO];
        lower_clock_source_ff <= wdata[`BIT_LOWER_CLOCK_SOURCE];
        input_invert_ff <= wdata[`BIT_INPUT_INVERT];
        output_invert_ff <= wdata[`BIT_OUTPUT_INVERT];
      end
      if (wr_gctl)
      begin
        upper_prescale_value_ff <= wdata[`PSC_HI:`PSC_LO];
        timer_mode_select_ff <= wdata[`MODE_HI:`MODE_LO];
        upper_half_reset_release_ff <= wdata[`BIT_UPPER_RELEASE];
        lower_half_reset_release_ff <= wdata[`BIT_LOWER_RELEASE];
      end
      if (wr_prd)
      begin
        upper_half_period_ff <= wdata[CNT_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Upper half prescaler and counter
  // ----------------------------------------
  // Match pulses bump one cycle later so the counter lags the match
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      upper_divide_down_count_ff <= 4'h0;
      bump_ff <= 1'b0;
    end
    else
    begin
      bump_ff <= upper_tick & psc_match;
      if (~upper_half_reset_release_ff)
      begin
        upper_divide_down_count_ff <= 4'h0;
      end
      else if (upper_tick)
      begin
        upper_divide_down_count_ff <= psc_match ? 4'h0
          : upper_divide_down_count_ff + 4'h1;
      end
    end
  end

  // Counter itself; a pending bump is dropped on the clearing clock
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      upper_half_counter_ff <= {CNT_W{1'b0}};
    end
    else
    begin
      if (wr_cnt)
      begin
        upper_half_counter_ff <= wdata[CNT_W-1:0];
      end
      else if (~upper_half_reset_release_ff)
      begin
        upper_half_counter_ff <= {CNT_W{1'b0}};
      end
      else if (upper_run & at_period & (upper_enable_mode_ff == `ENA_CONT))
      begin
        upper_half_counter_ff <= {CNT_W{1'b0}};
      end
      else if (bump_ff & ~once_done)
      begin
        upper_half_counter_ff <= upper_half_counter_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------
  // Clock source, divider and output path
  // ----------------------------------------
  // Two-flop synchronisers for the pin and the divide option
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
      div_s1_ff <= 1'b0;
      div_s2_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff <= timer_in_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_prev_ff <= pin_s2_ff;
      div_s1_ff <= input_divide_select;
      div_s2_ff <= div_s1_ff;
    end
  end

  // Divide-by-six of the synchronised pin, counted on its rising edges;
  // it runs even when not selected, so switching in gives no fresh phase
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt_ff <= 3'h0;
      div_clk_ff <= 1'b0;
      div_clk_prev_ff <= 1'b0;
    end
    else
    begin
      div_clk_prev_ff <= div_clk_ff;
      if (pin_s2_ff & ~pin_prev_ff)
      begin
        if (div_cnt_ff == `DIV_HALF_LAST)
        begin
          div_cnt_ff <= 3'h0;
          div_clk_ff <= ~div_clk_ff;
        end
        else
        begin
          div_cnt_ff <= div_cnt_ff + 3'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Tick, output pin and mode flags
  // ----------------------------------------
  // All outputs toward pins and the counter slice leave straight from flops
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lower_tick_ff <= 1'b0;
      output_level_status_ff <= 1'b0;
      timer_out_pin_ff <= 1'b0;
      mode_is_watchdog_ff <= 1'b0;
      mode_is_chained_ff <= 1'b0;
    end
    else
    begin
      lower_tick_ff <= nxt_lower_tick & lower_half_reset_release_ff;
      output_level_status_ff <= timer_out_raw;
      // Pin follows status, so it lags the raw signal by two cycles
      timer_out_pin_ff <= output_invert_ff ? ~output_level_status_ff
        : output_level_status_ff;
      mode_is_watchdog_ff <= is_mode(timer_mode_select_ff, `MODE_WATCHDOG);
      mode_is_chained_ff <= is_mode(timer_mode_select_ff, `MODE_DUAL_CHAINED);
    end
  end

endmodule

// ==== dv/timer_ctl_chk.sv ====
`timescale 1ns/1ns
module timer_ctl_chk (
  // Clock, reset, register port
  input wire clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata_ff,
  // Timer signals
  input wire timer_out_raw,
  input wire timer_out_pin_ff,
  input wire lower_tick_ff,
  input wire [1:0] timer_mode_select_ff,
  input wire mode_is_watchdog_ff,
  input wire mode_is_chained_ff
);
  reg inv_ff;
  reg src_ff;
  reg rel_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow of the control bits, so checks need no view inside
  always @(posedge clk or posedge rst)
    if (rst)
    begin
      inv_ff <= 1'b0;
      src_ff <= 1'b0;
      rel_ff <= 1'b0;
    end
    else if (wr && addr == 8'h20)
    begin
      inv_ff <= wdata[1];
      src_ff <= wdata[8];
    end
    else if (wr && addr == 8'h24)
      rel_ff <= wdata[0];
  property p_rdz;
    !$past(rd) |-> rdata_ff == 32'h0000_0000;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read data not idle");
  property p_wd;
    $past(timer_mode_select_ff) == timer_mode_select_ff
      |-> mode_is_watchdog_ff == (timer_mode_select_ff == 2'h2);
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog decode");
  property p_ch;
    $past(timer_mode_select_ff) == timer_mode_select_ff
      |-> mode_is_chained_ff == (timer_mode_select_ff == 2'h3);
  endproperty
  a_ch: assert property (p_ch) else $error("chained decode");
  property p_mw;
    wr && addr == 8'h24 |-> ##[1:2] timer_mode_select_ff == $past(wdata[3:2]);
  endproperty
  a_mw: assert property (p_mw) else $error("mode field not taken");
  property p_pin;
    $past(inv_ff) == inv_ff && $past(inv_ff, 2) == inv_ff
      |-> timer_out_pin_ff == ($past(timer_out_raw, 2) ^ inv_ff);
  endproperty
  a_pin: assert property (p_pin) else $error("output pin level");
  property p_tick;
    (!src_ff && rel_ff) [*3] |-> lower_tick_ff;
  endproperty
  a_tick: assert property (p_tick) else $error("internal tick missing");
  property p_res;
    $past(rd) && $past(addr) == 8'h24 |-> rdata_ff[31:16] == 16'h0000 && rdata_ff[7:4] == 4'h0;
  endproperty
  a_res: assert property (p_res) else $error("reserved bits set");
  property p_unm;
    $past(rd) && !($past(addr) inside {8'h18, 8'h1c, 8'h20, 8'h24})
      |-> rdata_ff == 32'h0000_0000;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule
bind timer_mode_prescale_output_ctl timer_ctl_chk u_chk (.clk, .rst, .addr, .wdata, .wr, .rd,
  .rdata_ff, .timer_out_raw, .timer_out_pin_ff, .lower_tick_ff, .timer_mode_select_ff,
  .mode_is_watchdog_ff, .mode_is_chained_ff);

// ==== dv/timer_pin_model.sv ====
`timescale 1ns/1ns
module timer_pin_model (
  // Clock
  input wire clk,
  // External timer input pin
  output reg timer_in_pin
);
  initial timer_in_pin = 1'b0;
  // Drive a level just after an edge; the pin keeps it
  task level(input bit v);
    @(posedge clk);
    timer_in_pin <= v;
  endtask
  // Pulses four cycles each way, slow enough for the two-flop sync
  task pulses(input int n);
    repeat (n)
    begin
      level(1'b1);
      repeat (3) @(posedge clk);
      level(1'b0);
      repeat (3) @(posedge clk);
    end
  endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  reg clk, rst, wr, rd, input_divide_select, timer_out_raw;
  reg [7:0] addr;
  reg [31:0] wdata, rv, w;
  wire timer_in_pin, timer_out_pin_ff, lower_tick_ff, mode_is_watchdog_ff, mode_is_chained_ff;
  wire [31:0] rdata_ff;
  wire [1:0] timer_mode_select_ff;
  integer miscompares = 0, n_compared = 0, ticks = 0, t0, i, p, k, n;
  timer_mode_prescale_output_ctl u_timer_mode_prescale_output_ctl (.clk, .rst, .addr, .wdata,
    .wr, .rd, .rdata_ff, .input_divide_select, .timer_out_raw, .timer_in_pin, .timer_out_pin_ff,
    .lower_tick_ff, .timer_mode_select_ff, .mode_is_watchdog_ff, .mode_is_chained_ff);
  timer_pin_model u_timer_pin_model (.clk, .timer_in_pin);
  // Both release bits always set, else 64-bit operation is undefined
  function [31:0] gw(input [1:0] m, input [3:0] ps);
    gw = {20'h0_0000, ps, 4'h0, m, 2'b11};
  endfunction
  function [31:0] cw(input [1:0] e, input s, input ii, input oi);
    cw = {8'h00, e, 13'h0000, s, 5'h00, ii, oi, 1'b0};
  endfunction
  // Upper half from the rules: step every ps+1 clocks, clear the clock after period
  function [31:0] up_model(input integer nclk, input [3:0] ps, input [31:0] prd);
    reg [3:0] dd;
    reg bmp;
    reg [31:0] c;
    integer j;
    begin
      dd = 4'h0;
      bmp = 1'b0;
      c = 32'h0000_0000;
      for (j = 0; j < nclk; j = j + 1)
      begin
        if (c == prd)
          c = 32'h0000_0000;
        else if (bmp)
          c = c + 32'h0000_0001;
        bmp = (dd == ps);
        dd = (dd == ps) ? 4'h0 : dd + 4'h1;
      end
      up_model = c;
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data is looked at only in the cycle after the strobe
  task rreg(input [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata_ff;
  endtask
  task conclude;
    $display("compared %0d bad %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Tick counter for the lower half
  always @(posedge clk)
    if (lower_tick_ff === 1'b1)
      ticks <= ticks + 1;
  // Hang guard, far beyond the thousand or so cycles the run needs
  initial
  begin
    #200000;
    miscompares = miscompares + 1;
    conclude;
  end
  initial
  begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
    input_divide_select = 1'b0; timer_out_raw = 1'b0;
    rv = $urandom(32'h3817);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rreg(8'h20); chk(rv, 32'h0000_0000);
    rreg(8'h24); chk(rv, 32'h0000_0000);
    wreg(8'h30, $urandom); rreg(8'h30); chk(rv, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1)
    begin
      w = $urandom;
      w[3:2] = i;
      wreg(8'h24, w); rreg(8'h24); chk(rv, w & 32'h0000_0f0f);
      chk(timer_mode_select_ff, i);
      chk(mode_is_watchdog_ff, i == 2);
      chk(mode_is_chained_ff, i == 3);
    end
    $display("mode test done");
    wreg(8'h24, gw(2'h1, 4'h0));
    for (i = 0; i < 16; i = i + 1)
    begin
      wreg(8'h20, cw(2'h0, 1'b0, 1'b0, i[3]));
      @(posedge clk);
      timer_out_raw <= $urandom;
      repeat (3) @(posedge clk);
      #1 chk(timer_out_pin_ff, timer_out_raw ^ i[3]);
      rreg(8'h20); chk(rv & 32'h0000_0003, {i[3], timer_out_raw});
    end
    $display("output test done");
    for (i = 0; i < 2; i = i + 1)
    begin
      p = i ? $urandom % 15 : 15;
      wreg(8'h20, cw(2'h0, 1'b0, 1'b0, 1'b0));
      // Releases low first, so divide-down and counter start from zero
      wreg(8'h24, 32'h0000_0004);
      wreg(8'h24, gw(2'h1, p)); wreg(8'h1c, 32'h0000_0003);
      wreg(8'h20, cw(2'h2, 1'b0, 1'b0, 1'b0));
      k = -1;
      repeat (3)
      begin
        n = $urandom % 40;
        repeat (n) @(posedge clk);
        k = k + n + 2;
        rreg(8'h18); chk(rv, up_model(k, p, 32'h0000_0003));
      end
      rreg(8'h24); chk(rv[15:12] <= p, 1);
      wreg(8'h20, cw(2'h0, 1'b0, 1'b0, 1'b0)); wreg(8'h18, 32'h0000_0000);
      wreg(8'h1c, 32'h0000_0002); wreg(8'h20, cw(2'h1, 1'b0, 1'b0, 1'b0));
      repeat (3 * (p + 1) + 20) @(posedge clk);
      rreg(8'h18); chk(rv, 32'h0000_0002);
      wreg(8'h24, gw(2'h0, p)); wreg(8'h18, 32'h0000_0000);
      wreg(8'h20, cw(2'h2, 1'b0, 1'b0, 1'b0));
      repeat (40) @(posedge clk);
      rreg(8'h18); chk(rv, 32'h0000_0000);
    end
    $display("prescale test done");
    wreg(8'h24, gw(2'h1, 4'h0)); wreg(8'h20, cw(2'h0, 1'b0, 1'b1, 1'b0));
    repeat (5) @(posedge clk);
    #1 t0 = ticks;
    repeat (20) @(posedge clk);
    #1 chk(ticks - t0, 20);
    for (i = 0; i < 4; i = i + 1)
    begin
      @(posedge clk);
      input_divide_select <= i[1];
      wreg(8'h20, cw(2'h0, 1'b1, i[0], 1'b0));
      u_timer_pin_model.level(1'b0);
      repeat (20) @(posedge clk);
      #1 t0 = ticks;
      if (i[1])
        u_timer_pin_model.pulses(12);
      else
        u_timer_pin_model.level(1'b1);
      repeat (12) @(posedge clk);
      #1 chk(ticks - t0, i[1] ? 2 : !i[0]);
    end
    $display("tick test done");
    conclude;
  end
endmodule
